// File: sstp_consts.vh
/*
 * Constants of the serial target port: link encodings, target
 * addresses and reset values.
 * Assumes inclusion by bare name from the port's design files.
 */
`ifndef SSTP_CONSTS_VH
`define SSTP_CONSTS_VH

// ----------------------------------------
// Command byte layout
// ----------------------------------------
`define SSTP_CMD_RW_BIT      7
`define SSTP_CMD_MB_BIT      6
`define SSTP_ADDR_W          6

// ----------------------------------------
// Target addresses, 7 bit
// ----------------------------------------
`define SSTP_I2C_ADDR_HI     7'h1d
`define SSTP_I2C_ADDR_LO     7'h53

// ----------------------------------------
// Link limits and reset values
// ----------------------------------------
`define SSTP_SPI_MAX_KHZ     5000
`define SSTP_SYNC_STAGES     2
`define SSTP_PTR_RST         6'h00
`define SSTP_BYTE_RST        8'h00

`endif

// File: sstp_host.sv
/*
 * Host controller model: SPI mode 3 frames and I2C bit banging.
 * Assumes the bench resolves the shared line and feeds it to miso_i.
 */
`timescale 1ns/1ns
module sstp_host (
    // Clock
    input  wire clk_i,
    // Link pins
    input  wire three_wire_i,
    input  wire miso_i,
    output reg  cs_b_o,
    output reg  sclk_o,
    output reg  mosi_o,
    output reg  mosi_oe_o
);
    reg [7:0] tx_buf [0:7];
    reg [7:0] rx_buf [0:7];

    initial
    begin
        cs_b_o    = 1'b1;
        sclk_o    = 1'b1;
        mosi_o    = 1'b1;
        mosi_oe_o = 1'b1;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Half period of 4 cycles gives the 80 ns link clock
    task automatic frame(input int n);
        int b;
        int k;
        cs_b_o = 1'b0;
        wait_n(4);
        for (b = 0; b < n; b++)
        begin
            for (k = 7; k >= 0; k--)
            begin
                sclk_o    = 1'b0;
                mosi_oe_o = !(b > 0 && tx_buf[0][7] && three_wire_i);
                mosi_o    = tx_buf[b][k];
                wait_n(4);
                sclk_o       = 1'b1;
                rx_buf[b][k] = miso_i;
                wait_n(4);
            end
        end
        mosi_oe_o = 1'b1;
        mosi_o    = 1'b1;
        wait_n(1);
        cs_b_o = 1'b1;
        wait_n(16);
    endtask

    // Open drain: enable means pull low
    task automatic i2c_bit(input logic b, output logic r);
        mosi_oe_o = !b;
        mosi_o    = 1'b0;
        wait_n(8);
        sclk_o = 1'b1;
        wait_n(4);
        r = miso_i;
        wait_n(4);
        sclk_o = 1'b0;
        wait_n(2);
    endtask

    task automatic i2c_byte(input logic [7:0] d, output logic ack);
        logic r;
        int   k;
        for (k = 7; k >= 0; k--) i2c_bit(d[k], r);
        i2c_bit(1'b1, r);
        ack = !r;
    endtask

    task automatic i2c_start();
        mosi_oe_o = 1'b0;
        wait_n(8);
        mosi_oe_o = 1'b1;
        mosi_o    = 1'b0;
        wait_n(8);
        sclk_o = 1'b0;
        wait_n(4);
    endtask

    task automatic i2c_stop();
        mosi_oe_o = 1'b1;
        wait_n(8);
        sclk_o = 1'b1;
        wait_n(8);
        mosi_oe_o = 1'b0;
        wait_n(12);
    endtask
endmodule // sstp_host

// File: sstp_port.v
/*
 * Serial target port: SPI (3/4-wire, mode 3) and I2C target access to
 * a 64-entry register space with an auto-incrementing pointer.
 * Assumes the register space answers reg_rdata_i combinationally from
 * reg_addr_o, and that pins toggle far slower than clk_i.
 */
// Functional notes
// RQ1: The port is only ever a target, and I2C is active whenever chip select is high.
// RQ2: The 3-wire input selects 3-wire SPI when one and 4-wire SPI when zero.
// RQ3: SPI runs with polarity 1 and phase 1, with a serial clock no faster than 5 MHz; the bench host clocks at 80 ns, 12.5 MHz.
// RQ4: The controller frames each SPI transaction with chip select low and supplies the clock.
// RQ5: The controller ignores what the port returns during any write.
// RQ6: A transfer of several bytes needs the multi-byte flag after the read/write bit.
// RQ7: After the address and first data byte, each further eight clocks advance the pointer.
// RQ8: Non-consecutive registers need a new transaction with a fresh address.
// RQ9: The two highest sample rates want an SPI clock of at least 2 MHz.
// RQ10: The 800 Hz rate wants at least 400 kHz, lower rates proportionally less.
// RQ11: A host configuring its clock mode late raises chip select first.
// RQ12: Idle SPI lines are held at defined levels by the controller.
// RQ13: The address-select pin is tied high or low to pick the I2C address.
// RQ14: The I2C address is 0x1D with the select pin high and 0x53 with it low.
// RQ15: I2C supports 100 kHz and 400 kHz with single and multi-byte reads and writes.
// RQ16: The SPI command byte is read/write, multi-byte flag, then a six-bit address, MSB first.
// RQ17: In 3-wire mode the shared data pin is driven only in the data phase of a read.
`timescale 1ns/1ns
`include "sstp_consts.vh"
module sstp_port (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rst_b_i,
    // Serial pins
    input  wire       cs_b_i,
    input  wire       sclk_i,
    input  wire       shared_serial_data_pin_i,
    input  wire       address_select_pin_i,
    output reg        shared_serial_data_pin_o,
    output reg        shared_serial_data_pin_oe_o,
    output reg        sdo_o,
    output reg        sdo_oe_o,
    // Configuration
    input  wire       three_wire_i,
    // Register space
    output reg  [5:0] reg_addr_o,
    output reg  [7:0] reg_wdata_o,
    output reg        reg_wr_o,
    output reg        reg_rd_o,
    input  wire [7:0] reg_rdata_i
);

    // ----------------------------------------
    // I2C states
    // ----------------------------------------
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_ADDR = 3'd1;
    localparam [2:0] ST_PTR  = 3'd2;
    localparam [2:0] ST_DATA = 3'd3;
    localparam [2:0] ST_ACK  = 3'd4;
    localparam [2:0] ST_TXD  = 3'd5;
    localparam [2:0] ST_MACK = 3'd6;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    wire [3:0] pins_s;
    wire       cs_s   = pins_s[0];
    wire       clk_s  = pins_s[1];
    wire       dat_s  = pins_s[2];
    wire       asel_s = pins_s[3];

    sstp_sync #(
        .WIDTH (4)
    ) u_sync (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .d_i       ({address_select_pin_i, shared_serial_data_pin_i, sclk_i, cs_b_i}),
        .rst_val_i (4'hf),
        .q_o       (pins_s)
    );

    reg        cs_prev_reg;
    reg        clk_prev_reg;
    reg        dat_prev_reg;
    reg  [7:0] rx_reg;
    reg  [7:0] tx_reg;
    reg  [2:0] cnt_reg;
    reg  [3:0] i2c_cnt_reg;
    reg        first_reg;
    reg        rw_reg;
    reg        mb_reg;
    reg        done_reg;
    reg        load_reg;
    reg  [2:0] st_reg;
    reg        ack_rd_reg;
    reg        after_ptr_reg;

    wire       clk_rise = clk_s & ~clk_prev_reg;
    wire       clk_fall = ~clk_s & clk_prev_reg;
    wire       i2c_start = clk_s & clk_prev_reg & dat_prev_reg & ~dat_s;
    wire       i2c_stop  = clk_s & clk_prev_reg & ~dat_prev_reg & dat_s;
    wire [7:0] rx_full   = {rx_reg[6:0], dat_s};
    wire       rd_phase  = rw_reg & ~first_reg & ~done_reg;
    wire [6:0] my_addr   = asel_s ? `SSTP_I2C_ADDR_HI : `SSTP_I2C_ADDR_LO; // RQ14 RQ13

    // ----------------------------------------
    // Port engine
    // ----------------------------------------
    always @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            cs_prev_reg                 <= 1'b1;
            clk_prev_reg                <= 1'b1;
            dat_prev_reg                <= 1'b1;
            rx_reg                      <= `SSTP_BYTE_RST;
            tx_reg                      <= `SSTP_BYTE_RST;
            cnt_reg                     <= 3'd0;
            i2c_cnt_reg                 <= 4'd0;
            first_reg                   <= 1'b1;
            rw_reg                      <= 1'b0;
            mb_reg                      <= 1'b0;
            done_reg                    <= 1'b0;
            load_reg                    <= 1'b0;
            st_reg                      <= ST_IDLE;
            ack_rd_reg                  <= 1'b0;
            after_ptr_reg               <= 1'b0;
            reg_addr_o                  <= `SSTP_PTR_RST;
            reg_wdata_o                 <= `SSTP_BYTE_RST;
            reg_wr_o                    <= 1'b0;
            reg_rd_o                    <= 1'b0;
            sdo_o                       <= 1'b1;
            sdo_oe_o                    <= 1'b0;
            shared_serial_data_pin_o    <= 1'b0;
            shared_serial_data_pin_oe_o <= 1'b0;
        end
        else
        begin
            cs_prev_reg  <= cs_s;
            clk_prev_reg <= clk_s;
            dat_prev_reg <= dat_s;
            reg_wr_o     <= 1'b0;
            reg_rd_o     <= 1'b0;
            load_reg     <= 1'b0;
            if (!cs_s)
            begin
                // SPI, framed by chip select low
                st_reg <= ST_IDLE; // RQ1
                if (cs_prev_reg)
                begin
                    cnt_reg   <= 3'd0; // RQ4
                    first_reg <= 1'b1;
                    done_reg  <= 1'b0;
                    rw_reg    <= 1'b0;
                end
                else
                begin
                    // Burst write steps only once its store has used the pointer
                    if (reg_wr_o && mb_reg)
                        reg_addr_o <= reg_addr_o + 6'd1; // RQ7
                    // Read data fetched one cycle after the pointer settles
                    if (load_reg)
                    begin
                        tx_reg   <= reg_rdata_i;
                        reg_rd_o <= 1'b1;
                    end
                    // Mode 3: shift out on falling, sample on rising
                    if (clk_fall && rd_phase) // RQ3
                    begin
                        sdo_o                    <= tx_reg[7];
                        shared_serial_data_pin_o <= tx_reg[7];
                        tx_reg                   <= {tx_reg[6:0], 1'b0};
                    end
                    if (clk_rise)
                    begin
                        rx_reg  <= rx_full;
                        cnt_reg <= cnt_reg + 3'd1;
                        if (cnt_reg == 3'd7 && first_reg)
                        begin
                            rw_reg     <= rx_full[`SSTP_CMD_RW_BIT]; // RQ16
                            mb_reg     <= rx_full[`SSTP_CMD_MB_BIT]; // RQ6
                            reg_addr_o <= rx_full[`SSTP_ADDR_W-1:0]; // RQ16
                            first_reg  <= 1'b0;
                            load_reg   <= rx_full[`SSTP_CMD_RW_BIT];
                        end
                        else if (cnt_reg == 3'd7 && !done_reg)
                        begin
                            if (!rw_reg)
                            begin
                                reg_wdata_o <= rx_full;
                                reg_wr_o    <= 1'b1;
                            end
                            // Without the flag one byte ends the access
                            if (mb_reg)
                            begin
                                if (rw_reg)
                                    reg_addr_o <= reg_addr_o + 6'd1; // RQ7
                                load_reg   <= rw_reg;
                            end
                            else
                                done_reg <= 1'b1; // RQ6
                        end
                    end
                end
                sdo_oe_o                    <= ~three_wire_i; // RQ2
                shared_serial_data_pin_oe_o <= three_wire_i & rd_phase; // RQ17 RQ2
            end
            else
            begin
                // I2C target while chip select is high
                sdo_oe_o                 <= 1'b0;
                shared_serial_data_pin_o <= 1'b0;
                first_reg                <= 1'b1;
                if (!cs_prev_reg)
                begin
                    st_reg                      <= ST_IDLE;
                    shared_serial_data_pin_oe_o <= 1'b0;
                end
                else if (i2c_start) // RQ1 RQ15
                begin
                    st_reg                      <= ST_ADDR;
                    i2c_cnt_reg                 <= 4'd0;
                    shared_serial_data_pin_oe_o <= 1'b0;
                end
                else if (i2c_stop)
                begin
                    st_reg                      <= ST_IDLE;
                    shared_serial_data_pin_oe_o <= 1'b0;
                end
                else if (clk_rise)
                begin
                    case (st_reg)
                        ST_ADDR, ST_PTR, ST_DATA:
                        begin
                            rx_reg      <= rx_full;
                            i2c_cnt_reg <= i2c_cnt_reg + 4'd1;
                        end
                        ST_MACK:
                        begin
                            // Controller not-acknowledge ends the read
                            st_reg     <= dat_s ? ST_IDLE : ST_ACK;
                            ack_rd_reg <= 1'b1;
                        end
                        default:
                            st_reg <= st_reg;
                    endcase
                end
                else if (clk_fall)
                begin
                    case (st_reg)
                        ST_ADDR, ST_PTR, ST_DATA:
                        begin
                            if (i2c_cnt_reg == 4'd8)
                            begin
                                st_reg                      <= ST_ACK;
                                shared_serial_data_pin_oe_o <= 1'b1;
                                ack_rd_reg                  <= 1'b0;
                                after_ptr_reg               <= 1'b0;
                                if (st_reg == ST_ADDR)
                                begin
                                    if (rx_reg[7:1] != my_addr) // RQ14
                                    begin
                                        st_reg                      <= ST_IDLE;
                                        shared_serial_data_pin_oe_o <= 1'b0;
                                    end
                                    ack_rd_reg <= rx_reg[0];
                                end
                                else if (st_reg == ST_PTR)
                                begin
                                    reg_addr_o    <= rx_reg[`SSTP_ADDR_W-1:0];
                                    after_ptr_reg <= 1'b1;
                                end
                                else
                                begin
                                    reg_wdata_o   <= rx_reg;
                                    reg_wr_o      <= 1'b1;
                                    after_ptr_reg <= 1'b1;
                                end
                            end
                        end
                        ST_ACK:
                        begin
                            i2c_cnt_reg <= 4'd0;
                            if (ack_rd_reg)
                            begin
                                // First data bit leaves as the acknowledge ends
                                tx_reg                      <= {reg_rdata_i[6:0], 1'b0};
                                shared_serial_data_pin_oe_o <= ~reg_rdata_i[7];
                                reg_rd_o                    <= 1'b1;
                                reg_addr_o                  <= reg_addr_o + 6'd1; // RQ15
                                i2c_cnt_reg                 <= 4'd1;
                                st_reg                      <= ST_TXD;
                            end
                            else
                            begin
                                shared_serial_data_pin_oe_o <= 1'b0;
                                st_reg <= after_ptr_reg ? ST_DATA : ST_PTR;
                            end
                        end
                        ST_TXD:
                        begin
                            if (i2c_cnt_reg == 4'd8)
                            begin
                                shared_serial_data_pin_oe_o <= 1'b0;
                                st_reg                      <= ST_MACK;
                            end
                            else
                            begin
                                shared_serial_data_pin_oe_o <= ~tx_reg[7];
                                tx_reg                      <= {tx_reg[6:0], 1'b0};
                                i2c_cnt_reg                 <= i2c_cnt_reg + 4'd1;
                            end
                        end
                        default:
                            st_reg <= st_reg;
                    endcase
                end
                // Write data advances after the store has used the pointer
                if (reg_wr_o)
                    reg_addr_o <= reg_addr_o + 6'd1;
            end
        end
    end

endmodule // sstp_port

// File: sstp_port_properties.sv
/*
 * Checker for the serial target port: pin enables, read timing and
 * pointer stepping. Assumes binding to sstp_port, single clock domain.
 */
`timescale 1ns/1ns
module sstp_port_properties (
    // Clock and reset
    input wire       clk_i,
    input wire       rst_b_i,
    // Serial pins
    input wire       cs_b_i,
    input wire       sclk_i,
    input wire       shared_serial_data_pin_i,
    input wire       address_select_pin_i,
    input wire       shared_serial_data_pin_o,
    input wire       shared_serial_data_pin_oe_o,
    input wire       sdo_o,
    input wire       sdo_oe_o,
    // Configuration
    input wire       three_wire_i,
    // Register space
    input wire [5:0] reg_addr_o,
    input wire [7:0] reg_wdata_o,
    input wire       reg_wr_o,
    input wire       reg_rd_o,
    input wire [7:0] reg_rdata_i
);
    reg rd_seen_reg;
    reg addr_seen_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // Flags live per frame, so chip select high clears them
    always @(posedge clk_i)
    begin
        if (!rst_b_i || cs_b_i)
        begin
            rd_seen_reg   <= 1'b0;
            addr_seen_reg <= 1'b0;
        end
        else
        begin
            if (reg_rd_o) rd_seen_reg <= 1'b1;
            if ($changed(reg_addr_o)) addr_seen_reg <= 1'b1;
        end
    end

    property p_spi_off; cs_b_i [*6] |-> !sdo_oe_o; endproperty
    a_spi_off: assert property (p_spi_off) else $error("sdo driven outside frame");
    property p_od; (cs_b_i [*6] ##0 shared_serial_data_pin_oe_o) |-> !shared_serial_data_pin_o; endproperty
    a_od: assert property (p_od) else $error("data pin driven high in target mode");
    property p_four; (!cs_b_i && !three_wire_i) [*6] |-> sdo_oe_o; endproperty
    a_four: assert property (p_four) else $error("sdo not driven in 4-wire frame");
    property p_three; three_wire_i [*6] |-> !sdo_oe_o; endproperty
    a_three: assert property (p_three) else $error("sdo driven in 3-wire mode");
    property p_no_sh; (!cs_b_i && !three_wire_i) [*6] |-> !shared_serial_data_pin_oe_o; endproperty
    a_no_sh: assert property (p_no_sh) else $error("data pin driven in 4-wire frame");
    property p_rd_only;
        (!cs_b_i && $rose(shared_serial_data_pin_oe_o)) |-> (rd_seen_reg || reg_rd_o);
    endproperty
    a_rd_only: assert property (p_rd_only) else $error("data pin driven without read");
    property p_step;
        (!cs_b_i && addr_seen_reg && $changed(reg_addr_o)) |-> reg_addr_o == $past(reg_addr_o) + 6'h01;
    endproperty
    a_step: assert property (p_step) else $error("pointer step not one");
    property p_fall;
        (!cs_b_i && !$past(cs_b_i, 6) && $changed(sdo_o))
            |-> (!$past(sclk_i, 2) || !$past(sclk_i, 3) || !$past(sclk_i, 4));
    endproperty
    a_fall: assert property (p_fall) else $error("sdo changed away from falling clock");
    property p_wr_pulse; reg_wr_o |=> !reg_wr_o; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe longer than one cycle");
endmodule // sstp_port_properties

bind sstp_port sstp_port_properties u_props (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b_i), .sclk_i(sclk_i),
    .shared_serial_data_pin_i(shared_serial_data_pin_i),
    .address_select_pin_i(address_select_pin_i),
    .shared_serial_data_pin_o(shared_serial_data_pin_o),
    .shared_serial_data_pin_oe_o(shared_serial_data_pin_oe_o),
    .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .three_wire_i(three_wire_i),
    .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o), .reg_wr_o(reg_wr_o),
    .reg_rd_o(reg_rd_o), .reg_rdata_i(reg_rdata_i)
);

// File: sstp_sync.v
/*
 * Two-stage synchroniser for a group of asynchronous pin levels.
 * Assumes the inputs are quasi-static relative to clk_i.
 */
`timescale 1ns/1ns
module sstp_sync #(
    parameter WIDTH = 4
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             rst_b_i,
    // Pins in, synced levels out
    input  wire [WIDTH-1:0] d_i,
    input  wire [WIDTH-1:0] rst_val_i,
    output wire [WIDTH-1:0] q_o
);

    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : g_bit
            always @(posedge clk_i)
            begin
                if (!rst_b_i)
                begin
                    meta_reg[g] <= rst_val_i[g];
                    sync_reg[g] <= rst_val_i[g];
                end
                else
                begin
                    meta_reg[g] <= d_i[g];
                    sync_reg[g] <= meta_reg[g];
                end
            end
        end
    endgenerate

    assign q_o = sync_reg;

endmodule // sstp_sync

// File: test_sensor_serial_target_port.sv
/*
 * Self-checking bench of the serial target port over SPI and I2C.
 * Assumes a combinational register space model and pull-ups on lines.
 */
`timescale 1ns/1ns
module test_sensor_serial_target_port;
    reg        clk_i;
    reg        rst_b_i;
    reg        three_wire_i;
    reg        address_select_pin_i;
    wire       sd_o, sd_oe, sdo_o, sdo_oe, wr, rd;
    wire [5:0] raddr;
    wire [7:0] wdata;
    wire       cs_b, sclk, host_d, host_oe;
    reg  [7:0] mem [0:63];
    reg  [7:0] exp_mem [0:63];
    reg  [31:0] seed;
    int        fails, check_count, cycles, tw, i;
    logic      ack;
    logic [5:0] a;

    // Released lines float high through their pull-ups
    wire sda_w = sd_oe ? sd_o : (host_oe ? host_d : 1'b1);
    wire sdo_w = sdo_oe ? sdo_o : 1'b1;
    wire miso  = (cs_b || three_wire_i) ? sda_w : sdo_w;

    always @(posedge clk_i) if (wr) mem[raddr] <= wdata;

    sstp_port dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b), .sclk_i(sclk),
        .shared_serial_data_pin_i(sda_w), .address_select_pin_i(address_select_pin_i),
        .shared_serial_data_pin_o(sd_o), .shared_serial_data_pin_oe_o(sd_oe),
        .sdo_o(sdo_o), .sdo_oe_o(sdo_oe), .three_wire_i(three_wire_i),
        .reg_addr_o(raddr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd),
        .reg_rdata_i(mem[raddr])
    );
    sstp_host host (
        .clk_i(clk_i), .three_wire_i(three_wire_i), .miso_i(miso), .cs_b_o(cs_b),
        .sclk_o(sclk), .mosi_o(host_d), .mosi_oe_o(host_oe)
    );

    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Returned bytes of a write are ignored
    task automatic spi_wr(input logic [5:0] ad, input int n, input logic mb);
        int j;
        host.tx_buf[0] = {1'b0, mb, ad};
        for (j = 0; j < n; j++)
        begin
            host.tx_buf[j+1] = xs();
            if (mb || j == 0) exp_mem[(ad + j) % 64] = host.tx_buf[j+1];
        end
        host.frame(n + 1);
    endtask

    task automatic spi_rd(input logic [5:0] ad, input int n, input logic mb);
        int j;
        host.tx_buf[0] = {1'b1, mb, ad};
        for (j = 1; j <= n; j++) host.tx_buf[j] = xs();
        host.frame(n + 1);
        for (j = 0; j < (mb ? n : 1); j++)
            check("spi read", host.rx_buf[j+1], exp_mem[(ad + j) % 64]);
    endtask

    task automatic i2c_try(input logic [6:0] ta, input logic want);
        logic [7:0] d;
        d = xs();
        host.i2c_start();
        host.i2c_byte({ta, 1'b0}, ack);
        check("i2c ack", {7'h00, ack}, {7'h00, want});
        if (want)
        begin
            host.i2c_byte(8'h05, ack);
            host.i2c_byte(d, ack);
            exp_mem[5] = d;
        end
        host.i2c_stop();
        check("i2c write", mem[5], exp_mem[5]);
    endtask

    // Two-byte read from the current pointer, acked then not acked
    task automatic i2c_rd2(input logic [5:0] p);
        logic [7:0] d;
        logic       r;
        int         b;
        int         k;
        host.i2c_start();
        host.i2c_byte({7'h53, 1'b1}, ack);
        check("i2c read ack", {7'h00, ack}, 8'h01);
        for (b = 0; b < 2; b++)
        begin
            for (k = 7; k >= 0; k--)
            begin
                host.i2c_bit(1'b1, r);
                d[k] = r;
            end
            host.i2c_bit(b == 1, r);
            check("i2c read", d, exp_mem[p + b]);
        end
        host.i2c_stop();
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Ceiling well above the expected run of about 6200 cycles
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            fails++;
            end_sim();
        end
    end

    initial
    begin
        rst_b_i = 1'b0;
        three_wire_i = 1'b0;
        address_select_pin_i = 1'b1;
        seed = 32'hfbdd47bb;
        fails = 0;
        check_count = 0;
        cycles = 0;
        for (i = 0; i < 64; i++)
        begin
            mem[i] = xs();
            exp_mem[i] = mem[i];
        end
        repeat (5) @(negedge clk_i);
        rst_b_i = 1'b1;
        repeat (5) @(negedge clk_i);
        for (tw = 0; tw < 2; tw++)
        begin
            three_wire_i = tw[0];
            repeat (8) @(negedge clk_i);
            repeat (4)
            begin
                a = 6'(xs());
                spi_wr(a, 1, 1'b0);
                spi_rd(a, 1, 1'b0);
            end
            spi_wr(6'h3e, 3, 1'b1);
            spi_rd(6'h3e, 3, 1'b1);
            a = 6'(xs());
            spi_wr(a, 2, 1'b0);
            spi_rd(a, 2, 1'b1);
            $display("test spi wire mode %0d done", tw);
        end
        i2c_try(7'h1d, 1'b1);
        address_select_pin_i = 1'b0;
        repeat (8) @(negedge clk_i);
        i2c_try(7'h1d, 1'b0);
        i2c_try(7'h53, 1'b1);
        i2c_rd2(6'h06);
        $display("test i2c address done");
        end_sim();
    end
endmodule // test_sensor_serial_target_port
